// [core/usbc_pkg.sv]
// constants, field layouts and state types of the serial status and rate block
// assumes a single 100 MHz clock and an 8-bit register port
package usbc_pkg;
   // register offsets
   localparam logic [7:0] OFS_CSR = 8'hc0;
   localparam logic [7:0] OFS_DBUF = 8'hc1;
   localparam logic [7:0] OFS_MANT = 8'hc2;
   localparam logic [7:0] OFS_UCR = 8'hc4;
   localparam logic [7:0] OFS_GCR = 8'hc5;
   localparam logic [7:0] OFS_IST = 8'hc6;
   localparam logic [7:0] OFS_IMSK = 8'hc7;
   // serial_control_status bit positions
   localparam int CSR_RXEN = 6;
   localparam int CSR_SLAVE = 5;
   localparam int CSR_FRAME = 4;
   localparam int CSR_PERR = 3;
   localparam int CSR_RXB = 2;
   localparam int CSR_TXB = 1;
   localparam int CSR_MODE = 7;
   // uart control bit positions
   localparam int UCR_FLUSH = 7;
   localparam int UCR_D9 = 5;
   localparam int UCR_BIT9 = 4;
   localparam int UCR_PAR = 3;
   localparam int UCR_SPB = 2;
   localparam int UCR_STOP = 1;
   localparam int UCR_START = 0;
   // interrupt status and mask bit positions
   localparam int IRQ_RX = 0;
   localparam int IRQ_TX = 1;
   localparam int IRQ_FRAME = 2;
   localparam int IRQ_PE = 3;
   localparam int IRQ_W = 4;
   // reset values
   localparam logic [7:0] MANT_RST = 8'h00;
   localparam logic [6:0] UCR_RST = 7'h02;
   // timing: 8 rate ticks per bit, uart sample and spi clock rise mid-bit
   localparam logic [2:0] SUB_LAST = 3'h7;
   localparam logic [2:0] SUB_MID = 3'h3;
   localparam logic [3:0] LAST8 = 4'h7;
   localparam logic [3:0] LAST9 = 4'h8;
   localparam int RATE_ACC_W = 25;
   localparam int RATE_INC_W = 41;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } usbc_req_t;

   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} usbc_tx_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usbc_rx_t;

   typedef struct packed {
      logic [RATE_ACC_W-1:0] acc;
      logic tick;
   } usbc_rate_t;

   typedef struct packed {
      logic [7:0] mant;
      logic [4:0] expo;
      logic [6:0] ucr;
      logic mode, rx_en, slave, frame_err, perr, rxb, txb, active;
      logic [7:0] rxbuf, txbuf;
      logic tx_pend;
      logic [IRQ_W-1:0] ist, imsk;
      logic [7:0] rdata;
      logic irq;
      usbc_tx_t tx_st;
      logic [8:0] tx_sh;
      logic [3:0] tx_cnt;
      logic [2:0] tx_sub;
      logic txd, sck, sck_oe;
      usbc_rx_t rx_st;
      logic [8:0] rx_sh;
      logic [3:0] rx_cnt;
      logic [2:0] rx_sub;
      logic sck_q;
      logic [3:0] sl_cnt;
      logic [7:0] sl_sh, sl_tx;
   } usbc_state_t;

   localparam usbc_state_t ST_RST = '{ucr: UCR_RST, txd: 1'b1, tx_st: TX_IDLE,
      rx_st: RX_IDLE, mant: MANT_RST, default: '0};
endpackage : usbc_pkg

// [core/usbc_rate.sv]
// fractional rate divider: one-cycle tick at eight times the bit rate
// assumes mantissa and exponent come from registers in the same clock
`timescale 1ns/1ns
`default_nettype none
module usbc_rate (
   input wire logic clk, // system clock
   input wire logic rst, // async reset, high
   input wire logic clear, // restart phase
   input wire logic [7:0] mant, // rate mantissa
   input wire logic [4:0] expo, // rate exponent
   output logic tick // oversample enable
);
   import usbc_pkg::*;
   usbc_rate_t s_r, s_nxt;
   logic [RATE_INC_W-1:0] inc, sum;

   // tick rate = (256 + mant) * 2^expo / 2^25 of the clock; saturates at every cycle
   always_comb begin
      inc = RATE_INC_W'({1'b1, mant}) << expo;
      sum = inc + RATE_INC_W'(s_r.acc);
      s_nxt = s_r;
      s_nxt.tick = |sum[RATE_INC_W-1:RATE_ACC_W];
      s_nxt.acc = sum[RATE_ACC_W-1:0];
      if (clear) begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;
endmodule : usbc_rate
`default_nettype wire

// [core/usbc_top.sv]
// serial unit: uart or spi master/slave with status, rate and interrupt registers
// assumes synchronous pins and a master that never overlaps strobes
`timescale 1ns/1ns
`default_nettype none
module usbc_top (
   input wire logic CLOCK, // 100 MHz system clock
   input wire logic RST, // async reset, high
   input wire usbc_pkg::usbc_req_t BUS, // register request
   output logic [7:0] RDATA, // read data, cycle after strobe
   output logic IRQ, // level interrupt
   input wire logic RXD, // uart rx, spi master in / slave in
   output logic TXD, // uart tx, spi master out / slave out
   input wire logic SCK_LINE, // spi clock level seen on pin
   output logic SCK_DRIVE, // spi clock level driven
   output logic SCK_OE, // spi clock driven (master)
   input wire logic SS_N // spi slave select, low active
);
   import usbc_pkg::*;
   usbc_state_t s_r, n;
   logic tick, flush, wcsr, rcsr, rdbuf;
   logic [IRQ_W-1:0] ev;
   logic [3:0] last;
   logic [7:0] rx_byte, csr_val;
   logic tx_ninth, rx_par_ok;

   assign flush = BUS.wr && BUS.addr == OFS_UCR && BUS.wdata[UCR_FLUSH];
   assign wcsr = BUS.wr && BUS.addr == OFS_CSR;
   assign rcsr = BUS.rd && BUS.addr == OFS_CSR;
   assign rdbuf = BUS.rd && BUS.addr == OFS_DBUF;
   assign last = s_r.ucr[UCR_BIT9] ? LAST9 : LAST8;
   assign rx_byte = s_r.ucr[UCR_BIT9] ? s_r.rx_sh[7:0] : s_r.rx_sh[8:1];
   // even parity when d9 is set, odd when clear; without parity d9 is sent raw
   assign tx_ninth = s_r.ucr[UCR_PAR] ? (s_r.ucr[UCR_D9] ? ^s_r.txbuf : ~^s_r.txbuf)
      : s_r.ucr[UCR_D9];
   assign rx_par_ok = s_r.rx_sh[8] == (s_r.ucr[UCR_D9] ? ^rx_byte : ~^rx_byte);
   assign csr_val = {s_r.mode, s_r.rx_en, s_r.slave, s_r.frame_err, s_r.perr,
      s_r.rxb, s_r.txb, s_r.active};

   usbc_rate u_rate (
      .clk(CLOCK),
      .rst(RST),
      .clear(flush),
      .mant(s_r.mant),
      .expo(s_r.expo),
      .tick(tick)
   );

   always_comb begin
      n = s_r;
      ev = '0;
      n.rdata = 8'h00;
      n.sck_q = SCK_LINE;
      n.sck_oe = !s_r.mode && !s_r.slave;
      // register reads; a status read clears the error flags, a data read clears rxb, the data goes out first
      if (BUS.rd) begin
         if (BUS.addr == OFS_CSR) begin
            n.rdata = csr_val;
            n.frame_err = 1'b0;
            n.perr = 1'b0;
         end else if (BUS.addr == OFS_DBUF) begin
            n.rdata = s_r.rxbuf;
            n.rxb = 1'b0;
         end else if (BUS.addr == OFS_MANT) begin
            n.rdata = s_r.mant;
         end else if (BUS.addr == OFS_UCR) begin
            n.rdata = {1'b0, s_r.ucr};
         end else if (BUS.addr == OFS_GCR) begin
            n.rdata = {3'h0, s_r.expo};
         end else if (BUS.addr == OFS_IST) begin
            n.rdata = {4'h0, s_r.ist};
         end else if (BUS.addr == OFS_IMSK) begin
            n.rdata = {4'h0, s_r.imsk};
         end
      end
      if (BUS.wr) begin
         if (BUS.addr == OFS_CSR) begin
            n.mode = BUS.wdata[CSR_MODE];
            n.rx_en = BUS.wdata[CSR_RXEN];
            n.slave = BUS.wdata[CSR_SLAVE];
            n.frame_err = s_r.frame_err & BUS.wdata[CSR_FRAME];
            n.perr = s_r.perr & BUS.wdata[CSR_PERR];
            n.rxb = s_r.rxb & BUS.wdata[CSR_RXB];
            n.txb = s_r.txb & BUS.wdata[CSR_TXB];
         end else if (BUS.addr == OFS_DBUF) begin
            n.txbuf = BUS.wdata;
            n.tx_pend = 1'b1;
         end else if (BUS.addr == OFS_MANT) begin
            n.mant = BUS.wdata;
         end else if (BUS.addr == OFS_UCR) begin
            n.ucr = BUS.wdata[6:0];
         end else if (BUS.addr == OFS_GCR) begin
            n.expo = BUS.wdata[4:0];
         end else if (BUS.addr == OFS_IST) begin
            n.ist = s_r.ist & ~BUS.wdata[IRQ_W-1:0];
         end else if (BUS.addr == OFS_IMSK) begin
            n.imsk = BUS.wdata[IRQ_W-1:0];
         end
      end
      // transmitter: uart frame or spi master byte, one bit per eight ticks
      case (s_r.tx_st)
         TX_IDLE: begin
            n.sck = 1'b0;
            if (s_r.mode) begin
               n.txd = !s_r.ucr[UCR_START];
            end
            if (s_r.tx_pend && s_r.mode) begin
               n.tx_pend = 1'b0;
               n.tx_sh = {tx_ninth, s_r.txbuf};
               n.tx_sub = 3'h0;
               n.txd = s_r.ucr[UCR_START];
               n.tx_st = TX_START;
            end else if (s_r.tx_pend && !s_r.slave) begin
               n.tx_pend = 1'b0;
               n.tx_sh = {1'b0, s_r.txbuf};
               n.tx_sub = 3'h0;
               n.tx_cnt = 4'h0;
               n.txd = s_r.txbuf[7];
               n.tx_st = TX_DATA;
            end
         end
         TX_START: begin
            if (tick) begin
               n.tx_sub = s_r.tx_sub + 3'h1;
               if (s_r.tx_sub == SUB_LAST) begin
                  n.tx_cnt = 4'h0;
                  n.txd = s_r.tx_sh[0];
                  n.tx_st = TX_DATA;
               end
            end
         end
         TX_DATA: begin
            if (tick) begin
               n.tx_sub = s_r.tx_sub + 3'h1;
               if (s_r.mode && s_r.tx_sub == SUB_LAST) begin
                  if (s_r.tx_cnt == last) begin
                     n.tx_cnt = 4'h0;
                     n.txd = s_r.ucr[UCR_STOP];
                     n.tx_st = TX_STOP;
                  end else begin
                     n.tx_cnt = s_r.tx_cnt + 4'h1;
                     n.tx_sh = {1'b0, s_r.tx_sh[8:1]};
                     n.txd = s_r.tx_sh[1];
                  end
               end else if (!s_r.mode && s_r.tx_sub == SUB_MID) begin
                  n.sck = 1'b1;
                  n.tx_sh = {s_r.tx_sh[7:0], RXD};
               end else if (!s_r.mode && s_r.tx_sub == SUB_LAST) begin
                  n.sck = 1'b0;
                  n.txd = s_r.tx_sh[7];
                  n.tx_cnt = s_r.tx_cnt + 4'h1;
                  if (s_r.tx_cnt == LAST8) begin
                     n.rxbuf = s_r.tx_sh[7:0];
                     ev[IRQ_TX] = 1'b1;
                     n.tx_st = TX_IDLE;
                  end
               end
            end
         end
         TX_STOP: begin
            if (tick) begin
               n.tx_sub = s_r.tx_sub + 3'h1;
               if (s_r.tx_sub == SUB_LAST) begin
                  if (s_r.ucr[UCR_SPB] && s_r.tx_cnt == 4'h0) begin
                     n.tx_cnt = 4'h1;
                  end else begin
                     ev[IRQ_TX] = 1'b1;
                     n.tx_st = TX_IDLE;
                  end
               end
            end
         end
         default: n.tx_st = TX_IDLE;
      endcase
      // uart receiver, held idle while disabled or in spi mode
      if (!(s_r.mode && s_r.rx_en)) begin
         n.rx_st = RX_IDLE;
      end else begin
         case (s_r.rx_st)
            RX_IDLE: begin
               if (RXD == s_r.ucr[UCR_START]) begin
                  n.rx_sub = 3'h0;
                  n.rx_st = RX_START;
               end
            end
            RX_START: begin
               if (tick) begin
                  n.rx_sub = s_r.rx_sub + 3'h1;
                  if (s_r.rx_sub == SUB_MID) begin
                     // a glitch shorter than half a bit is not a start
                     n.rx_sub = 3'h0;
                     n.rx_cnt = 4'h0;
                     n.rx_st = (RXD == s_r.ucr[UCR_START]) ? RX_DATA : RX_IDLE;
                  end
               end
            end
            RX_DATA: begin
               if (tick) begin
                  n.rx_sub = s_r.rx_sub + 3'h1;
                  if (s_r.rx_sub == SUB_LAST) begin
                     n.rx_sh = {RXD, s_r.rx_sh[8:1]};
                     n.rx_cnt = s_r.rx_cnt + 4'h1;
                     if (s_r.rx_cnt == last) begin
                        n.rx_st = RX_STOP;
                     end
                  end
               end
            end
            RX_STOP: begin
               if (tick) begin
                  n.rx_sub = s_r.rx_sub + 3'h1;
                  if (s_r.rx_sub == SUB_LAST) begin
                     n.rxbuf = rx_byte;
                     ev[IRQ_RX] = 1'b1;
                     ev[IRQ_FRAME] = RXD != s_r.ucr[UCR_STOP];
                     ev[IRQ_PE] = s_r.ucr[UCR_BIT9] && s_r.ucr[UCR_PAR]
                        && !rx_par_ok;
                     n.rx_st = RX_IDLE;
                  end
               end
            end
            default: n.rx_st = RX_IDLE;
         endcase
      end
      // spi slave: sample on rising clock, shift out on falling
      if (!s_r.mode && s_r.slave) begin
         n.txd = s_r.sl_tx[7];
         if (SS_N) begin
            n.sl_cnt = 4'h0;
            n.sl_tx = s_r.txbuf;
         end else if (SCK_LINE && !s_r.sck_q) begin
            n.sl_sh = {s_r.sl_sh[6:0], RXD};
            n.sl_cnt = s_r.sl_cnt + 4'h1;
            if (s_r.sl_cnt == LAST8) begin
               n.sl_cnt = 4'h0;
               n.rxbuf = {s_r.sl_sh[6:0], RXD};
               ev[IRQ_RX] = 1'b1;
            end
         end else if (!SCK_LINE && s_r.sck_q) begin
            n.sl_tx = (s_r.sl_cnt == 4'h0) ? s_r.txbuf : {s_r.sl_tx[6:0], 1'b0};
         end
      end
      // hardware sets come after software clears, so a set always wins
      if (ev[IRQ_RX]) begin
         n.rxb = 1'b1;
      end
      if (ev[IRQ_TX]) begin
         n.txb = 1'b1;
      end
      if (ev[IRQ_FRAME]) begin
         n.frame_err = 1'b1;
      end
      if (ev[IRQ_PE]) begin
         n.perr = 1'b1;
      end
      if (flush) begin
         n.tx_st = TX_IDLE;
         n.rx_st = RX_IDLE;
         n.tx_pend = 1'b0;
         n.sl_cnt = 4'h0;
         n.sck = 1'b0;
      end
      n.ist = n.ist | ev;
      n.irq = |(n.ist & n.imsk);
      if (!s_r.mode && s_r.slave) begin
         n.active = !SS_N;
      end else begin
         n.active = n.tx_st != TX_IDLE || n.rx_st != RX_IDLE;
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         s_r <= ST_RST;
      end else begin
         s_r <= n;
      end
   end

   assign RDATA = s_r.rdata;
   assign IRQ = s_r.irq;
   assign TXD = s_r.txd;
   assign SCK_DRIVE = s_r.sck;
   assign SCK_OE = s_r.sck_oe;

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);

   a_mant_write: assert property (
      BUS.wr && BUS.addr == OFS_MANT |=> s_r.mant == $past(BUS.wdata))
      else $error("mantissa write not stored");
   a_mode_role: assert property (
      wcsr |=> s_r.mode == $past(BUS.wdata[CSR_MODE])
         && s_r.slave == $past(BUS.wdata[CSR_SLAVE]))
      else $error("mode or role select wrong");
   a_rx_disabled: assert property (
      !(s_r.mode && s_r.rx_en) |=> s_r.rx_st == RX_IDLE)
      else $error("receiver ran while disabled");
   a_frame_rd_clear: assert property (
      rcsr && !ev[IRQ_FRAME] |=> !s_r.frame_err
         && RDATA[CSR_FRAME] == $past(s_r.frame_err))
      else $error("framing flag not cleared by read");
   a_pe_rd_clear: assert property (
      rcsr && !ev[IRQ_PE] |=> !s_r.perr)
      else $error("parity flag not cleared by read");
   a_rxb_dbuf: assert property (
      rdbuf && !ev[IRQ_RX] |=> !s_r.rxb && RDATA == $past(s_r.rxbuf))
      else $error("data read did not clear receive flag");
   a_rxb_discard: assert property (
      wcsr && !BUS.wdata[CSR_RXB] && !ev[IRQ_RX] |=> !s_r.rxb)
      else $error("receive flag not discarded");
   a_tx_done: assert property (
      ev[IRQ_TX] |=> s_r.txb && s_r.tx_st == TX_IDLE)
      else $error("transmit done not flagged");
   a_slave_active: assert property (
      !s_r.mode && s_r.slave && !wcsr |=> s_r.active == !$past(SS_N))
      else $error("activity not following slave select");
   a_flags_w1_keep: assert property (
      wcsr && BUS.wdata[CSR_FRAME:CSR_TXB] == 4'hf && ev == '0
         |=> {s_r.frame_err, s_r.perr, s_r.rxb, s_r.txb}
            == $past({s_r.frame_err, s_r.perr, s_r.rxb, s_r.txb}))
      else $error("writing one changed a flag");
   a_flush_idle: assert property (
      flush |=> s_r.tx_st == TX_IDLE && s_r.rx_st == RX_IDLE && !s_r.tx_pend)
      else $error("flush did not idle the unit");
endmodule : usbc_top
`default_nettype wire

// [dv/usbc_peer.sv]
// remote serial peer: uart line partner, spi slave responder, spi master driver
// assumes the device samples its pins on the same system clock
`timescale 1ns/1ns
`default_nettype none
module usbc_peer (
   input wire logic clk, // system clock
   input wire logic txd, // device serial out
   input wire logic sck, // device spi clock
   input wire logic sck_oe, // device drives spi clock
   output logic rxd, // device serial in
   output logic sck_line, // spi clock toward device
   output logic ss_n // slave select toward device
);
   logic line_r = 1'b1;
   logic resp = 1'b0;
   logic resp_q = 1'b0;
   logic sck_q = 1'b0;
   logic [7:0] sl_seed = 8'h00;
   logic [7:0] sl_sh = 8'h00;
   logic [7:0] sl_in = 8'h00;
   initial begin
      sck_line = 1'b0;
      ss_n = 1'b1;
   end
   assign rxd = resp ? sl_sh[7] : line_r;
   // spi slave, mode 0: take data on rise, move on fall; vacated bits get a toggling filler
   always @(posedge clk) begin
      sck_q <= sck;
      resp_q <= resp;
      // arming loads the reply here so that only this process writes the shifters
      if (resp && !resp_q) begin
         sl_sh <= sl_seed;
         sl_in <= 8'h00;
      end
      if (resp && sck_oe && sck && !sck_q) sl_in <= {sl_in[6:0], txd};
      if (resp && sck_oe && !sck && sck_q) sl_sh <= {sl_sh[6:0], ~sl_sh[7]};
   end
   task automatic spi_arm(input logic en, input logic [7:0] d);
      resp <= en;
      sl_seed <= d;
   endtask : spi_arm
   // uart frame, lsb first; the line idles at the stop level of a high-stop setup
   task automatic uart_send(input logic [8:0] d, input int nb, input logic stp, input int bc);
      for (int i = -1; i <= nb; i++) begin
         line_r <= (i < 0) ? 1'b0 : (i == nb) ? stp : d[i];
         repeat (bc) @(posedge clk);
      end
      line_r <= 1'b1;
   endtask : uart_send
   // start bit is timed; data sampled mid-bit, so bit 0 of the byte must be one
   task automatic uart_recv(input int bc, output logic [7:0] d, output int len);
      len = 0;
      for (int n = 0; n < 4000 && txd !== 1'b0; n++) @(posedge clk);
      while (txd === 1'b0 && len < 999) begin
         @(posedge clk);
         len++;
      end
      repeat (bc / 2) @(posedge clk);
      d[0] = txd;
      for (int i = 1; i < 8; i++) begin
         repeat (bc) @(posedge clk);
         d[i] = txd;
      end
   endtask : uart_recv
   // spi master toward a slave device; released data line shows the inverse of its last bit
   task automatic spi_xfer(input logic [7:0] mo, output logic [7:0] mi);
      ss_n <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         line_r <= mo[i];
         repeat (4) @(posedge clk);
         mi[i] = txd;
         sck_line <= 1'b1;
         repeat (4) @(posedge clk);
         sck_line <= 1'b0;
      end
      repeat (4) @(posedge clk);
      ss_n <= 1'b1;
      line_r <= ~mo[0];
   endtask : spi_xfer
endmodule : usbc_peer
`default_nettype wire

// [dv/tb.sv]
// self-checking bench of the serial status and rate block
// assumes usbc_top with its own assertions and the usbc_peer model on the pins
`timescale 1ns/1ns
`default_nettype none
module tb;
   import usbc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   usbc_req_t bus = '0;
   logic irq, txd, rxd, sck_drive, sck_oe, sck_line, ss_n;
   logic [7:0] rdata, v, d, e, m;
   int fail_count = 0;
   int comparisons = 0;
   int len;
   usbc_top uut (.CLOCK(clk), .RST(rst), .BUS(bus), .RDATA(rdata), .IRQ(irq), .RXD(rxd),
      .TXD(txd), .SCK_LINE(sck_line), .SCK_DRIVE(sck_drive), .SCK_OE(sck_oe), .SS_N(ss_n));
   usbc_peer peer (.clk(clk), .txd(txd), .sck(sck_drive), .sck_oe(sck_oe), .rxd(rxd),
      .sck_line(sck_line), .ss_n(ss_n));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
      comparisons++;
      if (got !== ex) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   // ninth bit that makes byte plus parity even
   function automatic logic even_par(input logic [7:0] b);
      return ^b;
   endfunction : even_par
   task automatic wr(input logic [7:0] a, input logic [7:0] dt);
      @(posedge clk);
      bus <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] dt);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 dt = rdata;
   endtask : rd
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] ex);
      rd(a, v);
      chk(nm, ex, v);
   endtask : rchk
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask : settle
   // status polling also clears the error flags; callers inspect v from the last read
   task automatic wait_csr(input int b);
      for (int n = 0; n < 300; n++) begin
         rd(OFS_CSR, v);
         if (v[b] === 1'b1) return;
      end
      chk("status wait", 8'h01, 8'h00);
   endtask : wait_csr
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   initial begin
      #400000;
      fail_count++;
      finish_test();
   end
   initial begin
      void'($urandom(32'h236d));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rchk("mant rst", OFS_MANT, 8'h00);
      rchk("csr rst", OFS_CSR, 8'h00);
      rchk("ucr rst", OFS_UCR, 8'h02);
      chk("sck_oe master", 8'h01, {7'h0, sck_oe});
      chk("irq rst", 8'h00, {7'h0, irq});
      rchk("unmapped", 8'hc3, 8'h00);
      for (int i = 0; i < 4; i++) begin
         e = (i == 0) ? 8'hff : 8'($urandom);
         wr(OFS_MANT, e);
         rchk("mant rw", OFS_MANT, e);
      end
      wr(OFS_GCR, 8'hff);
      rchk("expo", OFS_GCR, 8'h1f);
      // mantissa 0, exponent 15: a quarter tick per cycle, 32 cycles a bit
      wr(OFS_MANT, 8'h00);
      wr(OFS_GCR, 8'h0f);
      wr(OFS_CSR, 8'h80);
      settle();
      chk("sck_oe uart", 8'h00, {7'h0, sck_oe});
      e = 8'($urandom) | 8'h01;
      fork
         peer.uart_recv(32, d, len);
         begin
            wr(OFS_DBUF, e);
            repeat (40) @(posedge clk);
            rd(OFS_CSR, m);
         end
      join
      chk("active tx", 8'h81, m);
      chk("bit time", 8'h01, {7'h0, len inside {[29:35]}});
      chk("tx byte", e, d);
      wait_csr(CSR_TXB);
      rchk("idle", OFS_CSR, 8'h82);
      wr(OFS_CSR, 8'h9e);
      rchk("w1 keeps", OFS_CSR, 8'h82);
      wr(OFS_CSR, 8'h80);
      rchk("w0 clears", OFS_CSR, 8'h80);
      // abort inside a low data bit
      wr(OFS_DBUF, 8'h54);
      repeat (60) @(posedge clk);
      wr(OFS_UCR, 8'h82);
      settle();
      chk("flush txd", 8'h01, {7'h0, txd});
      repeat (400) @(posedge clk);
      rchk("flush idle", OFS_CSR, 8'h80);
      rchk("flush reads 0", OFS_UCR, 8'h02);
      wr(OFS_MANT, 8'hff);
      wr(OFS_GCR, 8'h10);
      peer.uart_send({1'b0, 8'h3c}, 8, 1'b1, 8);
      repeat (20) @(posedge clk);
      rchk("rx disabled", OFS_CSR, 8'h80);
      wr(OFS_CSR, 8'hc0);
      wr(OFS_IMSK, 8'h00);
      for (int i = 0; i < 4; i++) begin
         e = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         peer.uart_send({1'b0, e}, 8, 1'b1, 8);
         wait_csr(CSR_RXB);
         rd(OFS_DBUF, d);
         chk("rx byte", e, d);
         rchk("rxb cleared", OFS_CSR, 8'hc0);
      end
      settle();
      chk("irq masked", 8'h00, {7'h0, irq});
      wr(OFS_IMSK, 8'h01);
      settle();
      chk("irq on", 8'h01, {7'h0, irq});
      wr(OFS_IST, 8'h01);
      settle();
      chk("irq cleared", 8'h00, {7'h0, irq});
      wr(OFS_IST, 8'h0f);
      peer.uart_send({1'b0, 8'ha5}, 8, 1'b1, 8);
      wait_csr(CSR_RXB);
      wr(OFS_CSR, 8'hc0);
      rchk("discard", OFS_CSR, 8'hc0);
      e = 8'($urandom);
      peer.uart_send({1'b0, e}, 8, 1'b0, 8);
      wait_csr(CSR_RXB);
      chk("frame set", 8'h01, {7'h0, v[CSR_FRAME]});
      rchk("fe read clr", OFS_CSR, 8'hc4);
      rd(OFS_DBUF, d);
      // even parity in the ninth bit; second pass sends it wrong
      wr(OFS_UCR, 8'h3a);
      for (int k = 0; k < 2; k++) begin
         e = 8'($urandom);
         peer.uart_send({even_par(e) ^ k[0], e}, 9, 1'b1, 8);
         wait_csr(CSR_RXB);
         chk("perr", {7'h0, k[0]}, {7'h0, v[CSR_PERR]});
         rd(OFS_DBUF, d);
         rchk("perr read clr", OFS_CSR, 8'hc0);
      end
      wr(OFS_UCR, 8'h02);
      wr(OFS_CSR, 8'h00);
      e = 8'($urandom);
      d = 8'($urandom);
      peer.spi_arm(1'b1, d);
      wr(OFS_DBUF, e);
      wait_csr(CSR_TXB);
      chk("no rxb master", 8'h00, {7'h0, v[CSR_RXB]});
      chk("mosi", e, peer.sl_in);
      rd(OFS_DBUF, m);
      chk("miso", d, m);
      peer.spi_arm(1'b0, 8'h00);
      wr(OFS_CSR, 8'h20);
      e = 8'($urandom);
      d = 8'($urandom);
      wr(OFS_DBUF, e);
      settle();
      chk("sck_oe slave", 8'h00, {7'h0, sck_oe});
      rchk("ss idle", OFS_CSR, 8'h20);
      fork
         peer.spi_xfer(d, m);
         begin
            repeat (20) @(posedge clk);
            rd(OFS_CSR, v);
         end
      join
      chk("ss active", 8'h01, {7'h0, v[0]});
      chk("slave out", e, m);
      repeat (3) @(posedge clk);
      rd(OFS_CSR, v);
      chk("slave rxb", 8'h24, v & 8'hfd);
      rd(OFS_DBUF, v);
      chk("slave in", d, v);
      finish_test();
   end
endmodule : tb
`default_nettype wire
